// ---- pkg/ffsk_defines.svh ----
// Purpose: shared constants of the 1200 baud modem block
// Assumes: base tick is the 1.008 MHz rate, after any prescaling
// Notes: timing counts are in base ticks, except the lock count in half cycles
`ifndef FFSK_DEFINES_SVH
`define FFSK_DEFINES_SVH

// input clock choices and derived rates, in hertz, and sine steps per tone cycle
`define FFSK_XTAL_LO_HZ 1008000
`define FFSK_XTAL_HI_HZ 4032000
`define FFSK_BAUD_HZ 1200
`define FFSK_MARK_HZ 1200
`define FFSK_SPACE_HZ 1800
`define FFSK_STEPS 140

// division counts derived from the rates above
`define FFSK_PRESCALE (`FFSK_XTAL_HI_HZ / `FFSK_XTAL_LO_HZ)
`define FFSK_BIT_TICKS (`FFSK_XTAL_LO_HZ / `FFSK_BAUD_HZ)
`define FFSK_HALF_TICKS (`FFSK_BIT_TICKS / 2)
`define FFSK_MARK_DIV (`FFSK_XTAL_LO_HZ / (`FFSK_MARK_HZ * `FFSK_STEPS))
`define FFSK_SPACE_DIV (`FFSK_XTAL_LO_HZ / (`FFSK_SPACE_HZ * `FFSK_STEPS))
`define FFSK_HALF_STEPS (`FFSK_STEPS / 2)

// receiver half-cycle limits and nudge in base ticks, lock count in half cycles
`define FFSK_DEM_THRESH 350
`define FFSK_DEM_MIN 200
`define FFSK_DEM_MAX 520
`define FFSK_CD_COUNT 8
`define FFSK_NUDGE 8

// register byte offsets
`define FFSK_REG_STATUS 12'h000
`define FFSK_REG_INT_STAT 12'h004
`define FFSK_REG_INT_EN 12'h008
`define FFSK_REG_INT_CLR 12'h00c

// reset values
`define FFSK_RST_INT_EN 4'h0
`define FFSK_RST_INT_STAT 4'h0

// event bit positions
`define FFSK_EV_CD_RISE 0
`define FFSK_EV_CD_FALL 1
`define FFSK_EV_RX_BIT 2
`define FFSK_EV_TX_BIT 3

`endif

// ---- pkg/ffsk_pkg.sv ----
// Purpose: types of the 1200 baud modem block
// Assumes: constants come from ffsk_defines.svh
// Notes: one packed struct holds all state of each module
package ffsk_pkg;

    typedef enum logic {CD_IDLE, CD_LOCK} ffsk_cd_t;

    typedef struct packed {
        logic xs1;
        logic xs2;
        logic xs3;
        logic txd_s1;
        logic txd_s2;
        logic txen_s1;
        logic txen_s2;
        logic rxen_s1;
        logic rxen_s2;
        logic rate_s1;
        logic rate_s2;
        logic rxs_s1;
        logic rxs_s2;
        logic rxs_s3;
        logic [1:0] pre;
        logic [9:0] tx_cnt;
        logic tx_sync;
        logic tx_bit;
        logic [9:0] rx_cnt;
        logic rx_sync;
        logic rx_data;
        logic [9:0] hp;
        logic dec;
        ffsk_cd_t cd;
        logic [3:0] cd_cnt;
        logic carrier;
        logic [3:0] stat;
        logic [3:0] en;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ffsk_st_t;

    typedef struct packed {
        logic [7:0] phase;
        logic [2:0] div;
        logic mark;
        logic [7:0] sample;
        logic oe;
    } ffsk_tone_st_t;

endpackage

// ---- hw/ffsk_tone.sv ----
// Purpose: 140-step pseudo sine tone synthesiser, mark or space
// Assumes: tick_i is the 1.008 MHz base tick, one clk_sys cycle wide
// Notes: tone changes only at a zero crossing of the phase
`timescale 1ns/100ps
`include "ffsk_defines.svh"
module ffsk_tone
    import ffsk_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // control
    input wire logic en_i,
    input wire logic tick_i,
    input wire logic mark_i,
    // tone pin
    output logic [7:0] tone_o,
    output logic tone_oe
);

    ffsk_tone_st_t s_r;
    ffsk_tone_st_t s_nxt;
    logic [2:0] lim;

    // parabola per half cycle, offset binary about mid scale
    function automatic logic [7:0] ffsk_sine(input logic [7:0] p);
        logic [6:0] h;
        logic [16:0] prod;
        logic [6:0] y;
        h = (p < 8'(`FFSK_HALF_STEPS)) ? p[6:0]
            : 7'(p - 8'(`FFSK_HALF_STEPS));
        prod = 17'(h) * 17'(7'(`FFSK_HALF_STEPS) - h) * 17'h68;
        y = prod[16:10];
        ffsk_sine = (p < 8'(`FFSK_HALF_STEPS)) ? 8'h80 + 8'(y)
            : 8'h80 - 8'(y);
    endfunction

    assign lim = s_r.mark ? 3'(`FFSK_MARK_DIV) : 3'(`FFSK_SPACE_DIV);

    always_comb begin
        s_nxt = s_r;
        if (!en_i) begin
            s_nxt.phase = 8'h00;
            s_nxt.div = 3'h0;
            s_nxt.mark = 1'b1;
            s_nxt.oe = 1'b0;
            s_nxt.sample = 8'h80;
        end else begin
            s_nxt.oe = 1'b1;
            if (tick_i) begin
                if (s_r.div == 3'h1 && (s_r.phase == 8'h00 ||
                        s_r.phase == 8'(`FFSK_HALF_STEPS))) begin
                    s_nxt.mark = mark_i;
                end
                if (s_r.div == lim - 3'h1) begin
                    s_nxt.div = 3'h0;
                    s_nxt.phase = (s_r.phase == 8'(`FFSK_STEPS - 1))
                        ? 8'h00 : s_r.phase + 8'h01;
                end else begin
                    s_nxt.div = s_r.div + 3'h1;
                end
            end
            s_nxt.sample = ffsk_sine(s_nxt.phase);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '{phase: 8'h00, div: 3'h0, mark: 1'b1,
                     sample: 8'h80, oe: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tone_o = s_r.sample;
    assign tone_oe = s_r.oe;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_on_two;
        s_r.oe ##1 s_r.oe;
    endsequence

    property p_tone_zero_switch;
        s_on_two ##0 (s_r.mark != $past(s_r.mark)) |->
            ($past(s_r.phase) == 8'h00 || $past(s_r.phase) == 8'h46);
    endproperty
    a_tone_zero_switch: assert property (p_tone_zero_switch)
        else $error("tone changed away from a zero crossing");

    property p_tone_wrap;
        en_i && tick_i && s_r.phase == 8'h8b && s_r.div == lim - 3'h1
            |=> s_r.phase == 8'h00;
    endproperty
    a_tone_wrap: assert property (p_tone_wrap)
        else $error("phase did not wrap after step 139");

    property p_tone_off;
        !en_i |=> !s_r.oe && tone_o == 8'h80;
    endproperty
    a_tone_off: assert property (p_tone_off)
        else $error("tone pin driven while disabled");

    property p_tone_mark_div;
        en_i && tick_i && s_r.mark && s_r.div == 3'h5 |=>
            s_r.div == 3'h0 && s_r.phase != $past(s_r.phase);
    endproperty
    a_tone_mark_div: assert property (p_tone_mark_div)
        else $error("mark step not taken after six ticks");

endmodule

// ---- hw/ffsk_modem.sv ----
// Purpose: 1200 baud FFSK modem logic with APB status and interrupt
// Assumes: all pins but the apb slave and reset come from outside clk_sys and are synchronised
// Notes: the input clock pin is sampled; its rising edges pace all
//   timing, so clk_sys must run well above four times its rate
//
// Summary of operation
// - logic one sends 1200 Hz, zero 1800 Hz, switching at zero crossings
// - transmit and receive paths run independently, full duplex
// - transmit sync is a 1200 Hz square wave pacing bits and tone
// - enabled transmitter emits a 140-step stepped sine tone
// - disabled transmitter releases the tone pin to high impedance
// - transmit enable is active low
// - transmitter off holds transmit sync high and tone released
// - receiver enable active high; off forces data and carrier low
// - received bits are latched out on the recovered bit clock
// - carrier output is high while a valid tone is received
// - receive sync free-runs at 1200 Hz and pulls to data edges
// - all rates are divided down from the single input clock
// - 1.008 or 4.032 MHz input gives the same derived rates
// - rate select high picks 4.032 MHz, low picks 1.008 MHz
`timescale 1ns/100ps
`include "ffsk_defines.svh"
module ffsk_modem
    import ffsk_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // input clock and rate select
    input wire logic xtal_clk,
    input wire logic clk_rate,
    // transmitter pins
    input wire logic tx_en_n,
    input wire logic tx_data,
    output logic tx_sync,
    output logic [7:0] tone_o,
    output logic tone_oe,
    // receiver pins
    input wire logic rx_en,
    input wire logic rx_sig,
    output logic rx_sync,
    output logic rx_data,
    output logic carrier,
    // interrupt
    output logic irq
);

    ffsk_st_t s_r;
    ffsk_st_t s_nxt;
    logic tick;
    logic tx_on;
    logic rx_on;
    logic rx_edge;
    logic dem_bit;
    logic dem_ok;
    logic rx_turn;
    logic rx_lost;
    logic [3:0] ev;
    logic setup;
    logic access;

    // wrap a bit-period counter
    function automatic logic [9:0] ffsk_inc(input logic [9:0] c);
        ffsk_inc = (c == 10'(`FFSK_BIT_TICKS - 1)) ? 10'h000 : c + 10'h001;
    endfunction

    // register address decode
    function automatic logic ffsk_mapped(input logic [11:0] a);
        ffsk_mapped = (a == `FFSK_REG_STATUS) ||
            (a == `FFSK_REG_INT_STAT) || (a == `FFSK_REG_INT_EN) ||
            (a == `FFSK_REG_INT_CLR);
    endfunction

    assign tick = s_r.xs2 && !s_r.xs3 &&
        (!s_r.rate_s2 || s_r.pre == 2'(`FFSK_PRESCALE - 1));
    assign tx_on = !s_r.txen_s2;
    assign rx_on = s_r.rxen_s2;

    // half-cycle demodulator on input zero crossings
    assign rx_edge = s_r.rxs_s2 ^ s_r.rxs_s3;
    assign dem_bit = s_r.hp > 10'(`FFSK_DEM_THRESH);
    assign dem_ok = s_r.hp >= 10'(`FFSK_DEM_MIN) &&
        s_r.hp <= 10'(`FFSK_DEM_MAX);
    assign rx_turn = rx_on && rx_edge && dem_ok && (dem_bit != s_r.dec);
    assign rx_lost = rx_on && ((rx_edge && !dem_ok) ||
        (tick && s_r.hp == 10'(`FFSK_DEM_MAX + 1)));

    assign setup = psel && !penable;
    assign access = psel && penable && s_r.pready;

    ffsk_tone u_tone (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .en_i(tx_on),
        .tick_i(tick),
        .mark_i(s_r.tx_bit),
        .tone_o(tone_o),
        .tone_oe(tone_oe)
    );

    always_comb begin
        logic [9:0] c;
        c = 10'h000;
        s_nxt = s_r;
        ev = 4'h0;

        // two flops on every pin but the apb slave before use
        s_nxt.xs1 = xtal_clk;
        s_nxt.xs2 = s_r.xs1;
        s_nxt.xs3 = s_r.xs2;
        s_nxt.txd_s1 = tx_data;
        s_nxt.txd_s2 = s_r.txd_s1;
        s_nxt.txen_s1 = tx_en_n;
        s_nxt.txen_s2 = s_r.txen_s1;
        s_nxt.rxen_s1 = rx_en;
        s_nxt.rxen_s2 = s_r.rxen_s1;
        s_nxt.rate_s1 = clk_rate;
        s_nxt.rate_s2 = s_r.rate_s1;
        s_nxt.rxs_s1 = rx_sig;
        s_nxt.rxs_s2 = s_r.rxs_s1;
        s_nxt.rxs_s3 = s_r.rxs_s2;

        if (s_r.xs2 && !s_r.xs3) begin
            s_nxt.pre = s_r.pre + 2'h1;
        end

        if (!tx_on) begin
            s_nxt.tx_cnt = 10'h000;
        end else if (tick) begin
            s_nxt.tx_cnt = ffsk_inc(s_r.tx_cnt);
            if (s_r.tx_cnt == 10'h000) begin
                s_nxt.tx_bit = s_r.txd_s2;
                ev[`FFSK_EV_TX_BIT] = 1'b1;
            end
        end
        s_nxt.tx_sync = !tx_on || s_nxt.tx_cnt < 10'(`FFSK_HALF_TICKS);

        if (!rx_on) begin
            s_nxt.rx_cnt = 10'h000;
            s_nxt.rx_data = 1'b0;
            s_nxt.hp = 10'h000;
            s_nxt.dec = 1'b0;
            s_nxt.cd = CD_IDLE;
            s_nxt.cd_cnt = 4'h0;
            s_nxt.carrier = 1'b0;
        end else begin
            if (rx_edge) begin
                s_nxt.hp = 10'h000;
                if (dem_ok) begin
                    s_nxt.dec = dem_bit;
                end
            end else if (tick && s_r.hp != 10'h3ff) begin
                s_nxt.hp = s_r.hp + 10'h001;
            end

            c = tick ? ffsk_inc(s_r.rx_cnt) : s_r.rx_cnt;
            if (rx_turn && c != 10'h000) begin
                if (c < 10'(`FFSK_HALF_TICKS)) begin
                    c = (c < 10'(`FFSK_NUDGE)) ? 10'h000
                        : c - 10'(`FFSK_NUDGE);
                end else if (c + 10'(`FFSK_NUDGE) >=
                        10'(`FFSK_BIT_TICKS)) begin
                    c = c + 10'(`FFSK_NUDGE) - 10'(`FFSK_BIT_TICKS);
                end else begin
                    c = c + 10'(`FFSK_NUDGE);
                end
            end
            s_nxt.rx_cnt = c;

            if (tick && s_r.rx_cnt == 10'(`FFSK_HALF_TICKS)) begin
                s_nxt.rx_data = s_r.dec;
                ev[`FFSK_EV_RX_BIT] = 1'b1;
            end

            unique case (s_r.cd)
                CD_IDLE: begin
                    if (rx_lost) begin
                        s_nxt.cd_cnt = 4'h0;
                    end else if (rx_edge) begin
                        if (s_r.cd_cnt == 4'(`FFSK_CD_COUNT - 1)) begin
                            s_nxt.cd = CD_LOCK;
                            s_nxt.carrier = 1'b1;
                            ev[`FFSK_EV_CD_RISE] = 1'b1;
                        end else begin
                            s_nxt.cd_cnt = s_r.cd_cnt + 4'h1;
                        end
                    end
                end
                CD_LOCK: begin
                    if (rx_lost) begin
                        s_nxt.cd = CD_IDLE;
                        s_nxt.cd_cnt = 4'h0;
                        s_nxt.carrier = 1'b0;
                        ev[`FFSK_EV_CD_FALL] = 1'b1;
                    end
                end
            endcase
        end
        // receive sync rests low in powersave
        s_nxt.rx_sync = rx_on && s_nxt.rx_cnt < 10'(`FFSK_HALF_TICKS);
        if (!rx_on && s_r.carrier) begin
            ev[`FFSK_EV_CD_FALL] = 1'b1;
        end

        // apb: setup captures read data, access commits writes
        s_nxt.pready = setup;
        if (setup) begin
            s_nxt.pslverr = !ffsk_mapped(paddr);
            s_nxt.prdata = 32'h0000_0000;
            case (paddr)
                `FFSK_REG_STATUS: s_nxt.prdata = {27'h0, s_r.rate_s2,
                    rx_on, tx_on, s_r.rx_data, s_r.carrier};
                `FFSK_REG_INT_STAT: s_nxt.prdata = {28'h0, s_r.stat};
                `FFSK_REG_INT_EN: s_nxt.prdata = {28'h0, s_r.en};
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end else if (access) begin
            s_nxt.pslverr = 1'b0;
        end
        if (access && pwrite && paddr == `FFSK_REG_INT_EN) begin
            s_nxt.en = pwdata[3:0];
        end
        // a new event wins over a clear in the same cycle
        s_nxt.stat = s_r.stat | ev;
        if (access && pwrite && paddr == `FFSK_REG_INT_CLR) begin
            s_nxt.stat = (s_r.stat & ~pwdata[3:0]) | ev;
        end
        s_nxt.irq = |(s_nxt.stat & s_nxt.en);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
            s_r.txen_s1 <= 1'b1;
            s_r.txen_s2 <= 1'b1;
            s_r.tx_sync <= 1'b1;
            s_r.tx_bit <= 1'b1;
            s_r.cd <= CD_IDLE;
            s_r.stat <= `FFSK_RST_INT_STAT;
            s_r.en <= `FFSK_RST_INT_EN;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign tx_sync = s_r.tx_sync;
    assign rx_sync = s_r.rx_sync;
    assign rx_data = s_r.rx_data;
    assign carrier = s_r.carrier;
    assign irq = s_r.irq;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_apb_setup;
        psel && !penable;
    endsequence

    sequence s_apb_access;
        psel && penable && pready;
    endsequence

    property p_apb_answer;
        s_apb_setup ##1 (psel && penable) |-> s_apb_access;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("access phase not answered at once");

    property p_tx_powersave;
        s_r.txen_s2 |=> tx_sync && s_r.tx_cnt == 10'h000;
    endproperty
    a_tx_powersave: assert property (p_tx_powersave)
        else $error("transmit sync not held high in powersave");

    property p_rx_powersave;
        !s_r.rxen_s2 |=> !rx_data && !carrier && !rx_sync;
    endproperty
    a_rx_powersave: assert property (p_rx_powersave)
        else $error("receiver outputs active in powersave");

    property p_tx_period;
        tx_on && s_r.txen_s1 == 1'b0 && tick && s_r.tx_cnt == 10'h347
            |=> s_r.tx_cnt == 10'h000 && tx_sync;
    endproperty
    a_tx_period: assert property (p_tx_period)
        else $error("transmit bit period is not 840 ticks");

    property p_tx_take;
        tx_on && s_r.txen_s1 == 1'b0 && tick && s_r.tx_cnt == 10'h000
            |=> s_r.tx_bit == $past(s_r.txd_s2);
    endproperty
    a_tx_take: assert property (p_tx_take)
        else $error("transmit bit not taken at sync rise");

    property p_rx_latch;
        s_r.rxen_s2 && $past(s_r.rxen_s2) && $changed(rx_data) |->
            $past(tick) && $past(s_r.rx_cnt) == 10'h1a4;
    endproperty
    a_rx_latch: assert property (p_rx_latch)
        else $error("receive data moved off the recovered clock");

    property p_cd_rise;
        $rose(carrier) |-> $past(s_r.cd_cnt) == 4'h7 && s_r.cd == CD_LOCK;
    endproperty
    a_cd_rise: assert property (p_cd_rise)
        else $error("carrier raised before eight good half cycles");

    property p_prescale;
        s_r.rate_s2 && tick |-> s_r.pre == 2'h3;
    endproperty
    a_prescale: assert property (p_prescale)
        else $error("high rate input not divided by four");

    // level output: high exactly while an enabled status bit is set
    property p_irq_level;
        irq == |(s_r.stat & s_r.en);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt does not follow enabled status");

endmodule

// ---- sim/ffsk_partner.sv ----
// Purpose: host serial port, input clock and radio path facing the modem
// Assumes: tone half periods are handed over in ns by the bench
// Notes: the input clock runs free, unrelated in phase to clk_sys
`timescale 1ns/100ps
module ffsk_partner
    import ffsk_pkg::*;
(
    // input clock
    output logic xtal_clk,
    // host serial port
    input wire logic tx_sync,
    input wire logic tx_bit_i,
    output logic tx_data,
    // radio path
    input wire logic rx_on_i,
    input wire logic [31:0] rx_half_i,
    output logic rx_sig
);
    // offset of 7 ns keeps edges clear of the system clock edges
    initial begin
        xtal_clk = 1'b0;
        #7;
        forever #24 xtal_clk = ~xtal_clk;
    end

    // one bit per sync, moved on the fall
    initial tx_data = 1'b1;
    always @(negedge tx_sync) begin
        tx_data <= tx_bit_i;
    end

    // sliced tone; with no signal it keeps its level, so no edges arrive
    initial begin
        rx_sig = 1'b0;
        forever begin
            if (rx_on_i)
                #(rx_half_i) rx_sig = ~rx_sig;
            else
                #48;
        end
    end
endmodule

// ---- sim/ffsk_modem_tb.sv ----
// Purpose: self-checking bench of the 1200 baud modem block
// Assumes: 250 MHz system clock, 48 ns input clock at the low rate
// Notes: times are compared in ns; one base tick is 48 ns
`timescale 1ns/100ps
`include "ffsk_defines.svh"
module ffsk_modem_tb
    import ffsk_pkg::*;
;
    localparam int HALF_NS = 48 * `FFSK_HALF_TICKS;
    localparam int SPACE_NS = 13440;
    logic clk_sys, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, int_en;
    logic pready, pslverr, clk_rate = 0, tx_en_n = 1, rx_en = 0;
    logic tx_sync, tone_oe, rx_sync, rx_data, carrier, irq;
    logic [7:0] tone_o, seed = 8'h5d;
    logic tx_bit = 1, rx_on = 0;
    logic [31:0] rx_half = HALF_NS;
    wire xtal_clk, tx_data, rx_sig;
    logic [33:0] notes[$];
    logic [33:0] note;
    int miscompares = 0, total_checks = 0;
    time t0;

    ffsk_modem DUT (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xtal_clk(xtal_clk), .clk_rate(clk_rate),
        .tx_en_n(tx_en_n), .tx_data(tx_data), .tx_sync(tx_sync),
        .tone_o(tone_o), .tone_oe(tone_oe), .rx_en(rx_en),
        .rx_sig(rx_sig), .rx_sync(rx_sync), .rx_data(rx_data),
        .carrier(carrier), .irq(irq));
    ffsk_partner far_end (.xtal_clk(xtal_clk), .tx_sync(tx_sync),
        .tx_bit_i(tx_bit), .tx_data(tx_data), .rx_on_i(rx_on),
        .rx_half_i(rx_half), .rx_sig(rx_sig));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [31:0] pins();
        return {26'h0, tx_sync, tone_oe, rx_sync, rx_data, carrier, irq};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask

    // one transfer; the expected answer is noted for the monitor
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [32:0] exp);
        @(posedge clk_sys);
        notes.push_back({~wr, exp});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // no wait count assumed; only the watchdog ends a hang
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            chk1(pslverr, note[32]);
            if (note[33])
                check(prdata, note[31:0]);
        end
    end

    initial begin
        // the tests need about 380 us; a hang stops a little later
        #420000;
        miscompares++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        check(pins(), 32'h20);
        arst_n <= 1'b1;
        apb(1'b0, `FFSK_REG_INT_EN, 32'h0, 33'h0);
        apb(1'b0, `FFSK_REG_INT_STAT, 32'h0, 33'h0);
        apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h7fc, 32'hffffffff, {1'b1, 32'h0});
        seed = lfsr(seed);
        int_en = {30'h0, seed[0], 1'b1};
        apb(1'b1, `FFSK_REG_INT_EN, int_en, 33'h0);
        apb(1'b0, `FFSK_REG_INT_EN, 32'h0, {1'b0, int_en});
        $display("test registers done");
        // both halves start together: full duplex
        tx_en_n <= 1'b0;
        rx_en <= 1'b1;
        rx_on <= 1'b1;
        @(negedge tx_sync);
        t0 = $time;
        @(posedge tx_sync);
        check(32'($time - t0), HALF_NS);
        t0 = $time;
        @(negedge tx_sync);
        check(32'($time - t0), HALF_NS);
        @(posedge tone_o[7]);
        t0 = $time;
        @(posedge tone_o[7]);
        check(32'($time - t0), 2 * HALF_NS);
        chk1(tone_oe, 1'b1);
        // the mark tone wraps on the sync rise, so wait on the fall
        repeat (2) @(negedge tx_sync);
        apb(1'b0, `FFSK_REG_STATUS, 32'h0, 33'h0f);
        chk1(irq, 1'b1);
        apb(1'b1, `FFSK_REG_INT_EN, 32'h0, 33'h0);
        settle();
        chk1(irq, 1'b0);
        apb(1'b1, `FFSK_REG_INT_EN, int_en, 33'h0);
        settle();
        chk1(irq, 1'b1);
        apb(1'b1, `FFSK_REG_INT_CLR, 32'hf, 33'h0);
        settle();
        chk1(irq, 1'b0);
        $display("test mark done");
        tx_bit <= 1'b0;
        rx_half <= SPACE_NS;
        repeat (2) @(posedge tx_sync);
        @(posedge tone_o[7]);
        t0 = $time;
        @(posedge tone_o[7]);
        check(32'($time - t0), 2 * SPACE_NS);
        chk1(rx_data, 1'b0);
        chk1(carrier, 1'b1);
        // steady space: no decision change, so no nudge
        @(negedge rx_sync);
        t0 = $time;
        @(posedge rx_sync);
        check(32'($time - t0), HALF_NS);
        $display("test space done");
        // a pending half cycle may end before the 521 quiet ticks of
        // the loss limit start, so wait 900 ticks of 12 clocks each
        rx_on <= 1'b0;
        repeat (900 * 12) @(posedge clk_sys);
        chk1(carrier, 1'b0);
        rx_en <= 1'b0;
        repeat (24) @(posedge clk_sys);
        check(pins() & 32'h0e, 32'h0);
        tx_en_n <= 1'b1;
        repeat (24) @(posedge clk_sys);
        check(32'({tx_sync, tone_oe, tone_o}), 32'h280);
        clk_rate <= 1'b1;
        settle();
        apb(1'b0, `FFSK_REG_STATUS, 32'h0, 33'h10);
        // let the monitor take the last answer before the verdict
        settle();
        $display("test powersave done");
        conclude();
    end
endmodule
